// File: sync_rx_pkg.sv
// Constants, offsets and types shared by the synchronous master receiver
package sync_rx_pkg;

	// ************************************************************
	// Bus geometry
	// ************************************************************
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int CHAR_W = 8;
	localparam int EVT_W  = 2;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_DATA   = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_BAUD   = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_MASK   = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_DIV    = 5'h14;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTRL_SINGLE   = 0;
	localparam int CTRL_CONT     = 1;
	localparam int CTRL_MODE     = 2;
	localparam int CTRL_RXIF     = 3;
	localparam int DATA_VALID    = 8;
	localparam int BAUD_OVF      = 7;
	localparam int BAUD_IDLE     = 6;
	localparam int BAUD_POL      = 4;
	localparam int BAUD_WIDE     = 3;
	localparam int BAUD_WAKE     = 1;
	localparam int BAUD_AUTO     = 0;
	localparam int EVT_CHAR      = 0;
	localparam int EVT_OVERRUN   = 1;

	// ************************************************************
	// Reset values and masks
	// ************************************************************
	localparam logic [7:0]       BAUD_WR_MASK = 8'h9B;
	localparam logic [7:0]       BAUD_RESET   = 8'h00;
	localparam logic [7:0]       DIV_RESET    = 8'h04;
	localparam logic [EVT_W-1:0] MASK_RESET   = 2'h0;
	localparam logic [2:0]       LAST_BIT     = 3'h7;
	localparam logic [1:0]       FIFO_DEPTH   = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_REST   = 2'b10
	} rx_state_t;

endpackage

// File: pin_sync3.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync3 (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin_in,
	output logic      level_out
);

	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic level;
	} sync_t;

	sync_t r_reg;
	sync_t r_next;

	// First stage feeds only the second; change accepted when stages two and three agree
	always_comb begin
		r_next     = r_reg;
		r_next.ff1 = pin_in;
		r_next.ff2 = r_reg.ff1;
		r_next.ff3 = r_reg.ff2;
		if (r_reg.ff2 == r_reg.ff3) begin
			r_next.level = r_reg.ff3;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign level_out = r_reg.level;

endmodule // pin_sync3

// File: sync_master_receive.sv
// Synchronous master receive path with Avalon-MM register slave
// Functional notes
// - In synchronous master receive the data pin output driver stays off so the far transmitter can drive it.
// - Reception starts when either the single-receive or the continuous-receive enable is set.
// - With only single-receive set, exactly one character worth of clock cycles is generated, then the clock stops.
// - Hardware clears single-receive once one character has been fully received.
// - While continuous-receive is set, clock cycles run back to back until software clears it.
// - Clearing continuous-receive mid-character stops the clock at once and drops the partial character.
// - With both enables set, single-receive clears after the first character and continuous control carries on.
// - The data pin is sampled on the trailing edge of each generated clock cycle and shifted into the shift register.
// - A complete character raises the receive interrupt flag and moves into a two-character receive FIFO; if the FIFO is full it is dropped and flags overrun.
// - Reading the receive data register returns the low eight bits of the oldest FIFO character.
// - The receive interrupt flag stays set while any unread character remains and clears only when the FIFO is empty.
`timescale 1ns/1ps
module sync_master_receive
	import sync_rx_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [DATA_W-1:0] avs_writedata,
	output logic      [DATA_W-1:0] avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              receive_data_pin_in,
	output logic                   receive_data_pin_out,
	output logic                   receive_data_pin_oe_b,
	output logic                   serial_clock_out,
	output logic                   serial_clock_oe_b,
	output logic                   irq
);

	typedef struct packed {
		rx_state_t             st;
		logic [7:0]            div_cnt;
		logic [2:0]            bit_cnt;
		logic [CHAR_W-1:0]     shift;
		logic                  cont_char;
		logic                  single_en;
		logic                  cont_en;
		logic                  mode_en;
		logic [7:0]            baud;
		logic [7:0]            div;
		logic [EVT_W-1:0]      status;
		logic [EVT_W-1:0]      mask;
		logic [1:0][CHAR_W-1:0] fifo;
		logic                  wr_ptr;
		logic                  rd_ptr;
		logic [1:0]            count;
		logic                  sclk;
		logic                  sclk_oe_b;
		logic                  data_out;
		logic                  data_oe_b;
		logic                  irq;
		logic                  waitrequest;
		logic [DATA_W-1:0]     rdata;
	} state_t;

	state_t              r_reg;
	state_t              r_next;
	logic                data_in;
	logic                tick;
	logic                abort;
	logic                complete;
	logic                push;
	logic                pop;
	logic                wr_ctrl;
	logic                pol;
	logic [CHAR_W-1:0]   sh_new;
	logic [EVT_W-1:0]    evt;
	logic [EVT_W-1:0]    clr;
	logic [DATA_W-1:0]   rd_val;

	// ************************************************************
	// Data pin synchroniser
	// ************************************************************
	pin_sync3 u_data_sync (
		.clk       (clk),
		.rst_b     (rst_b),
		.pin_in    (receive_data_pin_in),
		.level_out (data_in)
	);

	// ************************************************************
	// Read value decode
	// ************************************************************
	always_comb begin
		rd_val = '0;
		if (avs_address == OFF_CTRL) begin
			rd_val[CTRL_SINGLE] = r_reg.single_en;
			rd_val[CTRL_CONT]   = r_reg.cont_en;
			rd_val[CTRL_MODE]   = r_reg.mode_en;
			rd_val[CTRL_RXIF]   = (r_reg.count != 2'h0);
		end else if (avs_address == OFF_DATA) begin
			rd_val[CHAR_W-1:0] = r_reg.fifo[r_reg.rd_ptr];
			rd_val[DATA_VALID] = (r_reg.count != 2'h0);
		end else if (avs_address == OFF_BAUD) begin
			rd_val[7:0]       = r_reg.baud & BAUD_WR_MASK;
			rd_val[BAUD_IDLE] = (r_reg.st == ST_IDLE);
		end else if (avs_address == OFF_STATUS) begin
			rd_val[EVT_W-1:0] = r_reg.status;
		end else if (avs_address == OFF_MASK) begin
			rd_val[EVT_W-1:0] = r_reg.mask;
		end else if (avs_address == OFF_DIV) begin
			rd_val[7:0] = r_reg.div;
		end
	end

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		r_next   = r_reg;
		evt      = '0;
		clr      = '0;
		push     = 1'b0;
		pop      = 1'b0;
		tick     = 1'b0;
		complete = 1'b0;
		wr_ctrl  = 1'b0;
		pol      = r_reg.baud[BAUD_POL];
		sh_new   = {data_in, r_reg.shift[CHAR_W-1:1]};
		abort    = !r_reg.mode_en || (r_reg.cont_char && !r_reg.cont_en);

		// Half-period divider, held at zero while idle so the first edge is immediate
		if (r_reg.st == ST_IDLE) begin
			r_next.div_cnt = '0;
		end else if (r_reg.div_cnt == r_reg.div) begin
			tick           = 1'b1;
			r_next.div_cnt = '0;
		end else begin
			r_next.div_cnt = r_reg.div_cnt + 8'h01;
		end

		case (r_reg.st)
			ST_IDLE: begin
				r_next.sclk    = pol;
				r_next.bit_cnt = '0;
				if (r_reg.mode_en && (r_reg.single_en || r_reg.cont_en)) begin
					r_next.st        = ST_ACTIVE;
					r_next.sclk      = ~pol;
					r_next.cont_char = r_reg.cont_en;
				end
			end
			ST_ACTIVE: begin
				if (abort) begin
					r_next.st      = ST_IDLE;
					r_next.sclk    = pol;
					r_next.bit_cnt = '0;
				end else if (tick) begin
					r_next.sclk  = pol;
					r_next.shift = sh_new;
					r_next.st    = ST_REST;
					if (r_reg.bit_cnt == LAST_BIT) begin
						complete         = 1'b1;
						r_next.bit_cnt   = '0;
						r_next.single_en = 1'b0;
					end else begin
						r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
					end
				end
			end
			ST_REST: begin
				if (abort) begin
					r_next.st      = ST_IDLE;
					r_next.sclk    = pol;
					r_next.bit_cnt = '0;
				end else if (tick) begin
					if (r_reg.bit_cnt != 3'h0) begin
						r_next.st   = ST_ACTIVE;
						r_next.sclk = ~pol;
					end else if (r_reg.cont_en || r_reg.single_en) begin
						r_next.st        = ST_ACTIVE;
						r_next.sclk      = ~pol;
						r_next.cont_char = r_reg.cont_en;
					end else begin
						r_next.st = ST_IDLE;
					end
				end
			end
			default: begin
				r_next.st = ST_IDLE;
			end
		endcase

		// Completed character into the FIFO; a full FIFO drops it and flags overrun
		if (complete) begin
			evt[EVT_CHAR] = 1'b1;
			if (r_reg.count == FIFO_DEPTH) begin
				evt[EVT_OVERRUN] = 1'b1;
			end else begin
				push                      = 1'b1;
				r_next.fifo[r_reg.wr_ptr] = sh_new;
				r_next.wr_ptr             = ~r_reg.wr_ptr;
			end
		end

		// Bus: answer one cycle after the request, act on the edge that sees waitrequest low
		if ((avs_read || avs_write) && r_reg.waitrequest) begin
			r_next.waitrequest = 1'b0;
			r_next.rdata       = avs_read ? rd_val : '0;
		end else if (!r_reg.waitrequest) begin
			r_next.waitrequest = 1'b1;
			if (avs_write) begin
				if (avs_address == OFF_CTRL) begin
					wr_ctrl          = 1'b1;
					r_next.single_en = avs_writedata[CTRL_SINGLE];
					r_next.cont_en   = avs_writedata[CTRL_CONT];
					r_next.mode_en   = avs_writedata[CTRL_MODE];
				end else if (avs_address == OFF_BAUD) begin
					r_next.baud = avs_writedata[7:0] & BAUD_WR_MASK;
				end else if (avs_address == OFF_MASK) begin
					r_next.mask = avs_writedata[EVT_W-1:0];
				end else if (avs_address == OFF_DIV) begin
					r_next.div = avs_writedata[7:0];
				end
			end else if (avs_read) begin
				// Pop only what was shown, so a push during the wait is never lost
				if (avs_address == OFF_DATA && r_reg.rdata[DATA_VALID]) begin
					pop           = 1'b1;
					r_next.rd_ptr = ~r_reg.rd_ptr;
				end else if (avs_address == OFF_STATUS) begin
					clr = r_reg.rdata[EVT_W-1:0];
				end
			end
		end

		r_next.count = r_reg.count + {1'b0, push} - {1'b0, pop};
		// Set wins over the read clear
		r_next.status    = (r_reg.status & ~clr) | evt;
		r_next.irq       = |(r_next.status & r_next.mask);
		r_next.sclk_oe_b = ~r_next.mode_en;
		r_next.data_out  = 1'b0;
		r_next.data_oe_b = 1'b1;
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			r_reg             <= '0;
			r_reg.st          <= ST_IDLE;
			r_reg.baud        <= BAUD_RESET;
			r_reg.div         <= DIV_RESET;
			r_reg.mask        <= MASK_RESET;
			r_reg.sclk_oe_b   <= 1'h1;
			r_reg.data_oe_b   <= 1'h1;
			r_reg.waitrequest <= 1'h1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign avs_readdata          = r_reg.rdata;
	assign avs_waitrequest       = r_reg.waitrequest;
	assign receive_data_pin_out  = r_reg.data_out;
	assign receive_data_pin_oe_b = r_reg.data_oe_b;
	assign serial_clock_out      = r_reg.sclk;
	assign serial_clock_oe_b     = r_reg.sclk_oe_b;
	assign irq                   = r_reg.irq;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_data_pin_released: assert property (r_reg.mode_en |-> r_reg.data_oe_b)
		else $error("data pin driven in master receive");
	chk_rx_start_enable: assert property ((r_reg.st == ST_IDLE && r_reg.mode_en
		&& (r_reg.single_en || r_reg.cont_en))
		|=> (r_reg.st == ST_ACTIVE && r_reg.sclk != r_reg.baud[BAUD_POL]))
		else $error("reception did not start");
	chk_single_stops: assert property ((complete && !r_reg.cont_char && !r_reg.cont_en && !wr_ctrl)
		|=> r_reg.st == ST_REST ##[1:256] r_reg.st == ST_IDLE)
		else $error("single receive did not stop after one character");
	chk_single_cleared: assert property ((complete && !wr_ctrl) |=> !r_reg.single_en)
		else $error("single enable not cleared");
	chk_cont_runs_on: assert property ((r_reg.st == ST_REST && tick && !abort
		&& r_reg.bit_cnt == 3'h0 && r_reg.cont_en)
		|=> r_reg.st == ST_ACTIVE && r_reg.cont_char)
		else $error("continuous receive paused");
	// A data read may pop in the abort cycle, so the dropped character is checked at the push
	chk_abort_stops: assert property ((r_reg.st != ST_IDLE && r_reg.cont_char && !r_reg.cont_en)
		|-> (!push && !evt[EVT_CHAR]) ##1 (r_reg.st == ST_IDLE && r_reg.bit_cnt == 3'h0))
		else $error("partial character not discarded");
	chk_sample_trailing: assert property ((r_reg.st == ST_ACTIVE && tick && !abort)
		|=> (r_reg.shift[CHAR_W-1] == $past(data_in) && r_reg.sclk == r_reg.baud[BAUD_POL]))
		else $error("bit not sampled on trailing edge");
	chk_fifo_push: assert property ((complete && r_reg.count != FIFO_DEPTH && !pop)
		|=> (r_reg.count == $past(r_reg.count) + 2'h1 && r_reg.status[EVT_CHAR]))
		else $error("character not moved into FIFO");
	chk_read_oldest: assert property ((avs_read && r_reg.waitrequest && avs_address == OFF_DATA
		&& r_reg.count != 2'h0)
		|=> (!avs_waitrequest && avs_readdata[CHAR_W-1:0] == $past(r_reg.fifo[r_reg.rd_ptr])))
		else $error("data read not oldest character");
	chk_flag_holds: assert property ((pop && !push && r_reg.count == FIFO_DEPTH)
		|=> r_reg.count == 2'h1)
		else $error("receive flag lost with a character left");
	chk_baud_layout: assert property ((avs_read && r_reg.waitrequest && avs_address == OFF_BAUD)
		|=> (avs_readdata[5] == 1'b0 && avs_readdata[2] == 1'b0
		&& avs_readdata[BAUD_IDLE] == ($past(r_reg.st) == ST_IDLE)))
		else $error("baud control readback wrong");

	cov_single_char: cover property (complete && !r_reg.cont_char);
	cov_cont_two: cover property (complete && r_reg.cont_char ##[1:600] complete);
	cov_abort: cover property (r_reg.st == ST_ACTIVE && abort && r_reg.mode_en);
	cov_overrun: cover property (evt[EVT_OVERRUN]);

endmodule // sync_master_receive

// File: sync_slave_tx.sv
// Behavioural far-side synchronous transmitter feeding the data pin
`timescale 1ns/1ps
module sync_slave_tx (
	input  wire logic       clk,
	input  wire logic       sclk,
	input  wire logic       idle_level,
	input  wire logic [7:0] tx_byte,
	output logic            data_out
);
	logic       sclk_reg  = 1'b0;
	logic [2:0] bit_reg   = 3'h0;
	logic [5:0] quiet_reg = 6'h00;

	initial data_out = 1'b0;

	// A long idle gap means a new frame, so an aborted frame cannot skew the next one
	always @(posedge clk) begin
		sclk_reg <= sclk;
		if (sclk != idle_level) begin
			quiet_reg <= 6'h00;
		end else if (quiet_reg != 6'h3F) begin
			quiet_reg <= quiet_reg + 6'h01;
		end
		if (sclk_reg == idle_level && sclk != idle_level) begin
			data_out <= tx_byte[quiet_reg[5] ? 3'h0 : bit_reg];
			bit_reg  <= (quiet_reg[5] ? 3'h0 : bit_reg) + 3'h1;
		end else if (sclk_reg != idle_level && sclk == idle_level) begin
			// Hold time is over after the trailing edge: show a wrong level
			data_out <= ~data_out;
		end
	end
endmodule // sync_slave_tx

// File: sync_master_receive_bench.sv
// Self-checking bench for the synchronous master receiver
`timescale 1ns/1ps
module sync_master_receive_bench;
	import sync_rx_pkg::*;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              wr;
		logic [31:0]       wdata;
		logic [31:0]       exp;
	} row_t;

	logic              clk           = 1'b0;
	logic              rst_b         = 1'b0;
	logic [ADDR_W-1:0] avs_address   = '0;
	logic              avs_read      = 1'b0;
	logic              avs_write     = 1'b0;
	logic [DATA_W-1:0] avs_writedata = '0;
	logic [DATA_W-1:0] avs_readdata;
	logic              avs_waitrequest;
	logic              data_in;
	logic              data_out;
	logic              data_oe_b;
	logic              sclk;
	logic              sclk_oe_b;
	logic              irq;
	logic              sclk_q        = 1'b0;
	logic [7:0]        tx_byte       = 8'h00;
	logic              idle_tb       = 1'b0;
	logic [31:0]       rd            = '0;
	int                edges         = 0;
	int                base          = 0;
	int                miscompares   = 0;
	int                n_tests       = 0;
	row_t              rows [0:9]    = '{
		'{OFF_CTRL,   1'b0, 32'h0000_0000, 32'h0000_0000},
		'{OFF_BAUD,   1'b0, 32'h0000_0000, 32'h0000_0040},
		'{OFF_STATUS, 1'b0, 32'h0000_0000, 32'h0000_0000},
		'{OFF_MASK,   1'b0, 32'h0000_0000, 32'h0000_0000},
		'{OFF_DIV,    1'b0, 32'h0000_0000, 32'h0000_0004},
		'{OFF_MASK,   1'b1, 32'h0000_0003, 32'h0000_0003},
		'{OFF_DIV,    1'b1, 32'h0000_000F, 32'h0000_000F},
		'{OFF_BAUD,   1'b1, 32'hFFFF_FFFF, 32'h0000_00DB},
		'{OFF_BAUD,   1'b1, 32'h0000_0000, 32'h0000_0040},
		'{5'h18,      1'b1, 32'hFFFF_FFFF, 32'h0000_0000}
	};

	always #2.5 clk = ~clk;

	// Rising edges of the generated clock: one per bit in either polarity
	always @(posedge clk) begin
		sclk_q <= sclk;
		if (!sclk_q && sclk) begin
			edges <= edges + 1;
		end
	end

	sync_master_receive dut_u (
		.clk                   (clk),
		.rst_b                 (rst_b),
		.avs_address           (avs_address),
		.avs_read              (avs_read),
		.avs_write             (avs_write),
		.avs_writedata         (avs_writedata),
		.avs_readdata          (avs_readdata),
		.avs_waitrequest       (avs_waitrequest),
		.receive_data_pin_in   (data_in),
		.receive_data_pin_out  (data_out),
		.receive_data_pin_oe_b (data_oe_b),
		.serial_clock_out      (sclk),
		.serial_clock_oe_b     (sclk_oe_b),
		.irq                   (irq)
	);

	sync_slave_tx partner_u (
		.clk        (clk),
		// Undriven clock line rests at its idle level, so polarity writes cannot fake a bit
		.sclk       (sclk_oe_b ? idle_tb : sclk),
		.idle_level (idle_tb),
		.tx_byte    (tx_byte),
		.data_out   (data_in)
	);

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic summarize();
		if (miscompares == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (k = 0; k < 100; k++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) break;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k == 100) begin
			miscompares++;
			summarize();
		end
	endtask

	task automatic wait_single();
		int k;
		rd = '1;
		for (k = 0; k < 400 && rd[CTRL_SINGLE] !== 1'b0; k++) bus(1'b0, OFF_CTRL, 32'h0000_0000);
		if (rd[CTRL_SINGLE] !== 1'b0) begin
			miscompares++;
			summarize();
		end
	endtask

	task automatic wait_edges(input int n);
		int k;
		for (k = 0; k < 4000 && edges - base < n; k++) @(posedge clk);
		if (edges - base < n) begin
			miscompares++;
			summarize();
		end
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		int k;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (k = 0; k < 10; k++) begin
			if (rows[k].wr) bus(1'b1, rows[k].addr, rows[k].wdata);
			bus(1'b0, rows[k].addr, 32'h0000_0000);
			chk(rd, rows[k].exp);
		end
		// Single character, half period of sixteen system clocks
		tx_byte <= 8'hA5;
		base = edges;
		bus(1'b1, OFF_CTRL, 32'h0000_0005);
		wait_single();
		chk(32'(data_oe_b), 32'h0000_0001);
		repeat (40) @(posedge clk);
		chk(edges - base, 32'h0000_0008);
		bus(1'b0, OFF_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_000C);
		chk(32'(irq), 32'h0000_0001);
		bus(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		bus(1'b0, OFF_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_01A5);
		chk(32'(irq), 32'h0000_0000);
		bus(1'b0, OFF_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0004);
		// Continuous, dropped in the middle of the third character
		tx_byte <= 8'h3C;
		base = edges;
		bus(1'b1, OFF_CTRL, 32'h0000_0006);
		wait_edges(20);
		bus(1'b1, OFF_CTRL, 32'h0000_0004);
		repeat (40) @(posedge clk);
		chk(edges - base, 32'h0000_0014);
		chk(32'(sclk), 32'h0000_0000);
		bus(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		bus(1'b0, OFF_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_013C);
		bus(1'b0, OFF_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_000C);
		bus(1'b0, OFF_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_013C);
		bus(1'b0, OFF_DATA, 32'h0000_0000);
		chk(rd & 32'h0000_0100, 32'h0000_0000);
		// Both enables, running into a full receive queue
		tx_byte <= 8'h81;
		base = edges;
		bus(1'b1, OFF_CTRL, 32'h0000_0007);
		wait_edges(9);
		bus(1'b0, OFF_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_000E);
		wait_edges(25);
		bus(1'b1, OFF_CTRL, 32'h0000_0004);
		repeat (40) @(posedge clk);
		chk(edges - base, 32'h0000_0019);
		bus(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0003);
		bus(1'b0, OFF_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_0181);
		// Clock idling high; partner restarts its frame after a quiet stretch
		bus(1'b1, OFF_BAUD, 32'h0000_0010);
		idle_tb <= 1'b1;
		repeat (40) @(posedge clk);
		tx_byte <= 8'h5A;
		base = edges;
		bus(1'b1, OFF_CTRL, 32'h0000_0005);
		wait_single();
		repeat (40) @(posedge clk);
		chk(edges - base, 32'h0000_0008);
		chk(32'(sclk), 32'h0000_0001);
		bus(1'b0, OFF_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_0181);
		bus(1'b0, OFF_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_015A);
		summarize();
	end
endmodule // sync_master_receive_bench
